// file: core/bfs_supervisor.sv
// Breaker failure supervisor top with Avalon-MM register slave
//
// Behaviour
// RQ1: Status shows one of normal, started, retrip, failure, blocked.
// RQ2: Blocking input sampled once per processing cycle, held for that cycle.
// RQ3: Pick-up without blocking raises start and runs both delay timers.
// RQ4: Pick-up under blocking raises blocked only; no timing, no outputs.
// RQ5: Blocking during start drops start and clears timers as on release.
// RQ6: Outside source asserts blocking 5 ms before the delay expires.
// RQ7: One pick-up starts retrip and failure timers together.
// RQ8: Retrip enable, default on; when off, no retrip output at all.
// RQ9: Retrip after start lasts the retrip delay, 5 ms steps, 0.100 s.
// RQ10: Failure output after the failure delay, 5 ms steps, 0.200 s.
// RQ11: Retrip delay plus breaker and release times below failure delay.
// RQ12: Current-only mode runs timers on overcurrent, ignores trip output.
// RQ13: Current-only mode clears timers once currents fall below threshold.
// RQ14: Current-and-output mode holds timers at zero until trip output.
// RQ15: Current-and-output mode clears timers when either condition drops.
// RQ16: Current-or-output mode picks up on either condition.
// RQ17: Current-or-output mode clears timers only when both are gone.
// RQ18: Current-or-output mode fires retrip and failure after full delays.
// RQ19: Comparators release at 97 % of the pick-up threshold.
// RQ20: Static criterion setting selects pick-up; default current only.
// RQ21: Timers count 5 ms ticks; outputs on tick reaching the setting.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
module bfs_supervisor #(
  parameter int unsigned P_TICK_CYCLES = bfs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                            i_sys_clk,
  input  wire logic                            i_rst_b,
  // Avalon-MM slave
  input  wire logic [bfs_pkg::ADDR_W-1:0]      i_avs_address,
  input  wire logic                            i_avs_read,
  input  wire logic                            i_avs_write,
  input  wire logic [31:0]                     i_avs_writedata,
  output logic      [31:0]                     o_avs_readdata,
  output logic                                 o_avs_waitrequest,
  // Current magnitudes from the measurement chain
  input  wire logic [2:0][bfs_pkg::MAG_W-1:0]  i_phase_mag,
  input  wire logic [bfs_pkg::MAG_W-1:0]       i_resid_mag,
  // Pins
  input  wire logic                            i_trip_out_mon,
  input  wire logic                            i_block,
  // Supervision outputs
  output logic                                 o_start,
  output logic                                 o_second_trip,
  output logic                                 o_breaker_failure_output,
  output logic                                 o_blocked,
  output logic      [4:0]                      o_status
);

  localparam logic [bfs_pkg::TICK_W-1:0] TICK_LAST =
    bfs_pkg::TICK_W'(P_TICK_CYCLES - 1);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [bfs_pkg::TICK_W-1:0] tick_cnt_r, tick_cnt_nxt;
  logic                       tick_r, tick_nxt;
  logic                       blk_m_r, blk_y_r, mon_m_r, mon_y_r;
  logic                       blk_s_r, blk_s_nxt, blk_cur;
  logic                       rt_en_r, rt_en_nxt, res_en_r, res_en_nxt;
  bfs_pkg::bfs_mode_t         mode_r, mode_nxt;
  logic [bfs_pkg::MAG_W-1:0]  ph_thr_r, ph_thr_nxt, res_thr_r, res_thr_nxt;
  logic [bfs_pkg::DLY_W-1:0]  rt_dly_r, rt_dly_nxt, bf_dly_r, bf_dly_nxt;
  logic                       wait_r, wait_nxt, wr_en;
  logic [31:0]                rdata_r, rdata_nxt, rd_mux;
  bfs_pkg::bfs_state_t        state_r, state_nxt;
  logic                       start_r, start_nxt, rt_r, rt_nxt;
  logic                       bf_r, bf_nxt, blkd_r, blkd_nxt;
  logic                       oc, pick, run, rt_reach, bf_reach;
  logic [bfs_pkg::DLY_W-1:0]  rt_cnt, bf_cnt;

  bfs_meas_if meas ();

  // ****************************************************************
  // Processing-cycle tick and pin synchronisers
  // ****************************************************************
  // One tick every 5 ms paces all supervision decisions
  always_comb begin
    tick_nxt     = (tick_cnt_r == TICK_LAST);
    tick_cnt_nxt = tick_nxt ? '0 : tick_cnt_r + 1'b1;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
      blk_m_r    <= 1'b0;
      blk_y_r    <= 1'b0;
      mon_m_r    <= 1'b0;
      mon_y_r    <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
      blk_m_r    <= i_block;
      blk_y_r    <= blk_m_r;
      mon_m_r    <= i_trip_out_mon;
      mon_y_r    <= mon_m_r;
    end
  end

  // Block level frozen at the start of each processing cycle [RQ2]
  always_comb begin
    blk_s_nxt = tick_r ? blk_y_r : blk_s_r;
    blk_cur   = blk_s_nxt;
  end

  // ****************************************************************
  // Register slave
  // ****************************************************************
  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_mux = '0;
    case (i_avs_address)
      bfs_pkg::OFS_CTRL: begin
        rd_mux[bfs_pkg::CTRL_RT_EN_BIT]  = rt_en_r;
        rd_mux[bfs_pkg::CTRL_RES_EN_BIT] = res_en_r;
        rd_mux[bfs_pkg::CTRL_MODE_LSB +: 2] = mode_r;
      end
      bfs_pkg::OFS_PH_THR:  rd_mux[bfs_pkg::MAG_W-1:0] = ph_thr_r;
      bfs_pkg::OFS_RES_THR: rd_mux[bfs_pkg::MAG_W-1:0] = res_thr_r;
      bfs_pkg::OFS_RT_DLY:  rd_mux[bfs_pkg::DLY_W-1:0] = rt_dly_r;
      bfs_pkg::OFS_BF_DLY:  rd_mux[bfs_pkg::DLY_W-1:0] = bf_dly_r;
      bfs_pkg::OFS_STATUS: begin
        rd_mux[bfs_pkg::STS_STATE_LSB +: 5] = state_r;
        rd_mux[bfs_pkg::STS_PH_OC_BIT]  = meas.ph_oc;
        rd_mux[bfs_pkg::STS_RES_OC_BIT] = meas.res_oc;
        rd_mux[bfs_pkg::STS_MON_BIT]    = mon_y_r;
        rd_mux[bfs_pkg::STS_BLK_BIT]    = blk_s_r;
      end
      default: rd_mux = '0;
    endcase
  end

  // One wait cycle per access keeps read data off the address decode
  always_comb begin
    wait_nxt    = 1'b1;
    rdata_nxt   = rdata_r;
    wr_en       = i_avs_write && !wait_r;
    rt_en_nxt   = rt_en_r;
    res_en_nxt  = res_en_r;
    mode_nxt    = mode_r;
    ph_thr_nxt  = ph_thr_r;
    res_thr_nxt = res_thr_r;
    rt_dly_nxt  = rt_dly_r;
    bf_dly_nxt  = bf_dly_r;
    if ((i_avs_read || i_avs_write) && wait_r) begin
      wait_nxt  = 1'b0;
      rdata_nxt = rd_mux;
    end
    if (wr_en) begin
      case (i_avs_address)
        bfs_pkg::OFS_CTRL: begin
          rt_en_nxt  = i_avs_writedata[bfs_pkg::CTRL_RT_EN_BIT];   // [RQ8]
          res_en_nxt = i_avs_writedata[bfs_pkg::CTRL_RES_EN_BIT];
          // Selects pick-up criterion [RQ20]
          mode_nxt   = bfs_pkg::bfs_mode_t'(
            i_avs_writedata[bfs_pkg::CTRL_MODE_LSB +: 2]);
        end
        bfs_pkg::OFS_PH_THR:
          ph_thr_nxt  = i_avs_writedata[bfs_pkg::MAG_W-1:0];
        bfs_pkg::OFS_RES_THR:
          res_thr_nxt = i_avs_writedata[bfs_pkg::MAG_W-1:0];
        bfs_pkg::OFS_RT_DLY:
          rt_dly_nxt  = i_avs_writedata[bfs_pkg::DLY_W-1:0];  // [RQ9]
        bfs_pkg::OFS_BF_DLY:
          bf_dly_nxt  = i_avs_writedata[bfs_pkg::DLY_W-1:0];  // [RQ10]
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      wait_r    <= 1'b1;
      rdata_r   <= '0;
      rt_en_r   <= bfs_pkg::RT_EN_RST;
      res_en_r  <= bfs_pkg::RES_EN_RST;
      mode_r    <= bfs_pkg::MODE_CUR;                         // [RQ20]
      ph_thr_r  <= bfs_pkg::PH_THR_RST;
      res_thr_r <= bfs_pkg::RES_THR_RST;
      rt_dly_r  <= bfs_pkg::RT_DLY_RST;
      bf_dly_r  <= bfs_pkg::BF_DLY_RST;
    end else begin
      wait_r    <= wait_nxt;
      rdata_r   <= rdata_nxt;
      rt_en_r   <= rt_en_nxt;
      res_en_r  <= res_en_nxt;
      mode_r    <= mode_nxt;
      ph_thr_r  <= ph_thr_nxt;
      res_thr_r <= res_thr_nxt;
      rt_dly_r  <= rt_dly_nxt;
      bf_dly_r  <= bf_dly_nxt;
    end
  end

  // ****************************************************************
  // Current detection and pick-up criterion
  // ****************************************************************
  assign meas.mag[0]  = i_phase_mag[0];
  assign meas.mag[1]  = i_phase_mag[1];
  assign meas.mag[2]  = i_phase_mag[2];
  assign meas.mag[3]  = i_resid_mag;
  assign meas.ph_thr  = ph_thr_r;
  assign meas.res_thr = res_thr_r;
  assign meas.res_en  = res_en_r;

  bfs_ovc_detect u_det (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .meas      (meas)
  );

  // Criterion; reserved code falls back to current only
  always_comb begin
    oc = meas.ph_oc || meas.res_oc;
    case (mode_r)
      bfs_pkg::MODE_CUR_AND_DO: pick = oc && mon_y_r;     // [RQ14] [RQ15]
      bfs_pkg::MODE_CUR_OR_DO:  pick = oc || mon_y_r;     // [RQ16] [RQ17]
      default:                  pick = oc;                // [RQ12] [RQ13]
    endcase
    run = pick && !blk_cur;                               // [RQ4] [RQ5]
  end

  // ****************************************************************
  // Delay timers, both fed by the same start [RQ7]
  // ****************************************************************
  bfs_delay_timer u_rt_tmr (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_tick    (tick_r),
    .i_run     (run),
    .i_delay   (rt_dly_r),
    .o_count   (rt_cnt),
    .o_reach   (rt_reach)
  );

  bfs_delay_timer u_bf_tmr (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_tick    (tick_r),
    .i_run     (run),
    .i_delay   (bf_dly_r),
    .o_count   (bf_cnt),
    .o_reach   (bf_reach)
  );

  // ****************************************************************
  // Supervision state and outputs
  // ****************************************************************
  // Decided once per tick so the output matches the sampled block
  always_comb begin
    state_nxt = state_r;
    start_nxt = start_r;
    rt_nxt    = rt_r;
    bf_nxt    = bf_r;
    blkd_nxt  = blkd_r;
    if (tick_r) begin
      start_nxt = run;                                    // [RQ3] [RQ5]
      rt_nxt    = rt_reach && rt_en_r;                    // [RQ8] [RQ9] [RQ18]
      bf_nxt    = bf_reach;                               // [RQ10] [RQ18]
      blkd_nxt  = pick && blk_cur;                        // [RQ4]
      case (state_r)
        bfs_pkg::ST_NORMAL, bfs_pkg::ST_STARTED, bfs_pkg::ST_RETRIP,
        bfs_pkg::ST_BFAIL, bfs_pkg::ST_BLOCKED: begin
          if (pick && blk_cur) begin
            state_nxt = bfs_pkg::ST_BLOCKED;              // [RQ1]
          end else if (!run) begin
            state_nxt = bfs_pkg::ST_NORMAL;
          end else if (bf_reach) begin
            state_nxt = bfs_pkg::ST_BFAIL;
          end else if (rt_reach && rt_en_r) begin
            state_nxt = bfs_pkg::ST_RETRIP;
          end else begin
            state_nxt = bfs_pkg::ST_STARTED;
          end
        end
        default: state_nxt = bfs_pkg::ST_NORMAL;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      blk_s_r <= 1'b0;
      state_r <= bfs_pkg::ST_NORMAL;
      start_r <= 1'b0;
      rt_r    <= 1'b0;
      bf_r    <= 1'b0;
      blkd_r  <= 1'b0;
    end else begin
      blk_s_r <= blk_s_nxt;
      state_r <= state_nxt;
      start_r <= start_nxt;
      rt_r    <= rt_nxt;
      bf_r    <= bf_nxt;
      blkd_r  <= blkd_nxt;
    end
  end

  assign o_avs_readdata           = rdata_r;
  assign o_avs_waitrequest        = wait_r;
  assign o_start                  = start_r;
  assign o_second_trip            = rt_r;
  assign o_breaker_failure_output = bf_r;
  assign o_blocked                = blkd_r;
  assign o_status                 = state_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_tick_run;
    tick_r && run;
  endsequence

  sequence s_tick_idle;
    tick_r && !pick;
  endsequence

  chk_status_onehot: assert property ($onehot(o_status))         // [RQ1]
    else $error("status not one of five states");
  chk_block_held: assert property (!tick_r |=> $stable(blk_s_r))  // [RQ2]
    else $error("block level changed between ticks");
  chk_start_rise: assert property (                                // [RQ3]
      s_tick_run |=> o_start && !o_blocked)
    else $error("start missing after unblocked pick-up");
  chk_block_quiet: assert property (tick_r && pick && blk_cur |=>  // [RQ4]
      o_blocked && !o_start && !o_second_trip
      && !o_breaker_failure_output)
    else $error("blocked pick-up produced outputs");
  chk_block_clear: assert property (tick_r && blk_cur |=>          // [RQ5]
      rt_cnt == '0 && bf_cnt == '0 && !o_start)
    else $error("blocking did not release start");
  chk_timers_same: assert property (rt_cnt == bf_cnt)              // [RQ7]
    else $error("timers started apart");
  chk_retrip_off: assert property (                                // [RQ8]
      tick_r && !rt_en_r |=> !o_second_trip)
    else $error("retrip driven while disabled");
  chk_retrip_time: assert property (                               // [RQ9]
      (s_tick_run and (rt_en_r && rt_cnt >= rt_dly_r)) |=> o_second_trip)
    else $error("retrip late after delay");
  chk_bf_time: assert property (                                   // [RQ10]
      (s_tick_run and (bf_cnt >= bf_dly_r))
      |=> o_breaker_failure_output ##0 state_r == bfs_pkg::ST_BFAIL)
    else $error("failure output late after delay");
  chk_idle_clear: assert property (                                // [RQ13]
      s_tick_idle |=> bf_cnt == '0 ##1 !o_breaker_failure_output [*2])
    else $error("timers kept running without pick-up");
  chk_and_hold: assert property (tick_r && !blk_cur                // [RQ14]
      && mode_r == bfs_pkg::MODE_CUR_AND_DO && !(oc && mon_y_r)
      |=> rt_cnt == '0)
    else $error("and-mode timer ran without both conditions");
  chk_or_keep: assert property (tick_r && !blk_cur                 // [RQ17]
      && mode_r == bfs_pkg::MODE_CUR_OR_DO && (oc || mon_y_r)
      |=> o_start)
    else $error("or-mode pick-up dropped with a condition present");

endmodule : bfs_supervisor

// file: core/bfs_pkg.sv
// Constants, register map and types of the breaker failure supervisor
package bfs_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned PROC_CYCLE_MS   = 5;
  // Clock cycles in one processing cycle
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * PROC_CYCLE_MS;
  localparam int unsigned RT_DLY_DEF_MS   = 100;
  localparam int unsigned BF_DLY_DEF_MS   = 200;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned MAG_W   = 16;
  localparam int unsigned DLY_W   = 19;   // 1800 s in 5 ms steps
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned N_CH    = 4;    // Three phases and residual
  localparam int unsigned TICK_W  = 16;

  // Release at 97 % of the pick-up threshold
  localparam int unsigned HYST_NUM = 97;
  localparam int unsigned HYST_DEN = 100;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PH_THR  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RES_THR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RT_DLY  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_BF_DLY  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h14;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned CTRL_RT_EN_BIT  = 0;
  localparam int unsigned CTRL_RES_EN_BIT = 1;
  localparam int unsigned CTRL_MODE_LSB   = 2;
  localparam int unsigned STS_STATE_LSB   = 0;
  localparam int unsigned STS_PH_OC_BIT   = 5;
  localparam int unsigned STS_RES_OC_BIT  = 6;
  localparam int unsigned STS_MON_BIT     = 7;
  localparam int unsigned STS_BLK_BIT     = 8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic             RT_EN_RST   = 1'b1;
  localparam logic             RES_EN_RST  = 1'b0;
  localparam logic [MAG_W-1:0] PH_THR_RST  = 16'h0200;
  localparam logic [MAG_W-1:0] RES_THR_RST = 16'h0C00;
  localparam logic [DLY_W-1:0] RT_DLY_RST  = DLY_W'(RT_DLY_DEF_MS / PROC_CYCLE_MS);
  localparam logic [DLY_W-1:0] BF_DLY_RST  = DLY_W'(BF_DLY_DEF_MS / PROC_CYCLE_MS);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_CUR        = 2'h0,
    MODE_CUR_AND_DO = 2'h1,
    MODE_CUR_OR_DO  = 2'h2
  } bfs_mode_t;

  typedef enum logic [4:0] {
    ST_NORMAL  = 5'h01,
    ST_STARTED = 5'h02,
    ST_RETRIP  = 5'h04,
    ST_BFAIL   = 5'h08,
    ST_BLOCKED = 5'h10
  } bfs_state_t;

endpackage : bfs_pkg

// file: core/bfs_meas_if.sv
// Measurement bundle between the supervisor and its current detector
`timescale 1ns/100ps
interface bfs_meas_if;
  logic [bfs_pkg::MAG_W-1:0] mag [bfs_pkg::N_CH];
  logic [bfs_pkg::MAG_W-1:0] ph_thr;
  logic [bfs_pkg::MAG_W-1:0] res_thr;
  logic                      res_en;
  logic                      ph_oc;
  logic                      res_oc;

  modport det (input mag, ph_thr, res_thr, res_en, output ph_oc, res_oc);
  modport src (output mag, ph_thr, res_thr, res_en, input ph_oc, res_oc);
endinterface : bfs_meas_if

// file: core/bfs_ovc_detect.sv
// Overcurrent comparators with release hysteresis, one per channel
`timescale 1ns/100ps
module bfs_ovc_detect (
  // Clock and reset
  input wire logic     i_sys_clk,
  input wire logic     i_rst_b,
  // Measurements and flags
  bfs_meas_if.det      meas
);

  logic [bfs_pkg::N_CH-1:0] oc_r;
  logic [bfs_pkg::N_CH-1:0] oc_nxt;

  // ****************************************************************
  // Per-channel comparator
  // ****************************************************************
  for (genvar ch = 0; ch < bfs_pkg::N_CH; ch++) begin : g_ch
    logic [bfs_pkg::MAG_W-1:0] thr;
    logic [bfs_pkg::MAG_W-1:0] rel;
    logic [bfs_pkg::MAG_W+6:0] prod;
    logic                      en;

    // Last channel is the residual input
    assign thr  = (ch == bfs_pkg::N_CH - 1) ? meas.res_thr : meas.ph_thr;
    assign en   = (ch == bfs_pkg::N_CH - 1) ? meas.res_en : 1'b1;
    assign prod = thr * 7'(bfs_pkg::HYST_NUM);
    assign rel  = bfs_pkg::MAG_W'(prod / 7'(bfs_pkg::HYST_DEN));

    // Hold between release and pick-up levels to avoid chatter [RQ19]
    always_comb begin
      oc_nxt[ch] = oc_r[ch];
      if (!en) begin
        oc_nxt[ch] = 1'b0;
      end else if (meas.mag[ch] > thr) begin
        oc_nxt[ch] = 1'b1;
      end else if (meas.mag[ch] < rel) begin
        oc_nxt[ch] = 1'b0;
      end
    end
  end

  // Flag register
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      oc_r <= '0;
    end else begin
      oc_r <= oc_nxt;
    end
  end

  assign meas.ph_oc  = |oc_r[bfs_pkg::N_CH-2:0];
  assign meas.res_oc = oc_r[bfs_pkg::N_CH-1];

endmodule : bfs_ovc_detect

// file: core/bfs_delay_timer.sv
// Delay timer counting processing-cycle ticks while its start holds
`timescale 1ns/100ps
module bfs_delay_timer (
  // Clock and reset
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst_b,
  // Control
  input  wire logic                      i_tick,
  input  wire logic                      i_run,
  input  wire logic [bfs_pkg::DLY_W-1:0] i_delay,
  // Result
  output logic      [bfs_pkg::DLY_W-1:0] o_count,
  output logic                           o_reach
);

  logic [bfs_pkg::DLY_W-1:0] cnt_r;
  logic [bfs_pkg::DLY_W-1:0] cnt_nxt;

  // Count elapsed ticks, saturating; cleared when start drops [RQ21]
  always_comb begin
    cnt_nxt = cnt_r;
    if (i_tick) begin
      if (!i_run) begin
        cnt_nxt = '0;
      end else if (cnt_r != '1) begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  // Counter register
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Elapsed time reached on the first tick that meets the setting [RQ21]
  assign o_reach = i_run && (cnt_r >= i_delay);
  assign o_count = cnt_r;

endmodule : bfs_delay_timer

// file: test/bfs_breaker_model.sv
// Breaker model: fault current that the trip coils may interrupt
`timescale 1ns/100ps
module bfs_breaker_model (
  // Clock and scenario controls
  input  wire logic i_clk,
  input  wire logic i_fault,
  input  wire logic i_heal,
  // Trip commands from the device
  input  wire logic i_second_trip,
  input  wire logic i_bf_trip,
  // Current through the breaker
  output logic      o_current
);
  int   cnt_r  = 0;
  logic open_r = 1'b0;
  // Second coil clears only when told; upstream trip always clears
  always @(posedge i_clk) begin
    cnt_r <= (i_second_trip && i_heal) ? cnt_r + 1 : 0;
    if (!i_fault)
      open_r <= 1'b0;
    else if (cnt_r >= 4 || i_bf_trip)
      open_r <= 1'b1;
  end
  assign o_current = i_fault && !open_r;
endmodule : bfs_breaker_model

// file: test/bfs_supervisor_tb_top.sv
// Self-checking bench of the breaker failure supervisor
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  $display("[FAIL] %s exp %h got %h", nm, e, g); err_count++; end end
module bfs_supervisor_tb_top;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_b   = 1'b0;
  logic [7:0]  adr       = 8'h00;
  logic        rd = 1'b0, wr = 1'b0, mon = 1'b0, blk = 1'b0;
  logic        fault = 1'b0, heal = 1'b0, cur, wreq, st, rt, bf, bl;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic [15:0] mag = 16'h0000;
  logic [2:0]  ph = 3'h1;
  logic [4:0]  sts;
  logic [3:0]  outs;
  logic [35:0] exp_q[$], msk_q[$];
  int          err_count = 0, n_checks = 0, seed = 32'hc4763b68;
  // Ten cycles per tick keeps every delay short
  always #50 i_sys_clk = ~i_sys_clk;
  assign outs = {bl, bf, rt, st};
  bfs_supervisor #(.P_TICK_CYCLES(10)) dut (.i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_phase_mag({ph[2] && cur ? mag : 16'h0000,
    ph[1] && cur ? mag : 16'h0000, ph[0] && cur ? mag : 16'h0000}),
    .i_resid_mag(cur ? 16'h0c01 : 16'h0000), .i_trip_out_mon(mon),
    .i_block(blk),
    .o_start(st), .o_second_trip(rt), .o_breaker_failure_output(bf),
    .o_blocked(bl), .o_status(sts));
  bfs_breaker_model cb (.i_clk(i_sys_clk), .i_fault(fault), .i_heal(heal),
    .i_second_trip(rt), .i_bf_trip(bf), .o_current(cur));
  task automatic tally_and_finish();
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : cyc
  // Held until waitrequest is sampled low; a hang ends the run
  task automatic bus(input logic w, input logic [7:0] a, input int d);
    int k;
    @(posedge i_sys_clk);
    adr  <= a;
    wr   <= w;
    rd   <= !w;
    wdat <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge i_sys_clk);
      if (wreq === 1'b0) break;
    end
    wr <= 1'b0;
    rd <= 1'b0;
    if (k == 20) begin
      err_count++;
      tally_and_finish();
    end
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [35:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 0);
  endtask : rchk
  // Status word, outputs seen at the same edge
  task automatic sc(input logic [3:0] o, om, input logic [4:0] s, sm);
    rchk(8'h14, {o, 27'h0, s}, {om, 27'h0, sm});
  endtask : sc
  task automatic wait_for(input int b);
    int k;
    for (k = 0; k < 200; k++) begin
      @(posedge i_sys_clk);
      if (outs[b] === 1'b1) break;
    end
    if (k == 200) begin
      err_count++;
      tally_and_finish();
    end
  endtask : wait_for
  task automatic idle();
    fault <= 1'b0;
    mon   <= 1'b0;
    cyc(15);
  endtask : idle
  // Oldest note against read data and outputs at the completing edge
  always @(posedge i_sys_clk) begin
    if (rd && wreq === 1'b0 && exp_q.size() > 0)
      `CHK("read", exp_q[0] & msk_q[0], {outs, rdat} & msk_q[0])
    if (rd && wreq === 1'b0 && exp_q.size() > 0 && adr == 8'h14)
      `CHK("status", exp_q[0][4:0], sts)
    if (rd && wreq === 1'b0 && exp_q.size() > 0) begin
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  initial begin
    logic [7:0]  ad[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
    logic [31:0] dv[6] = '{32'h1, 32'h200, 32'hc00, 32'd20, 32'd40, 32'h0};
    cyc(6);
    i_rst_b <= 1'b1;
    bus(1'b1, 8'h18, 32'hffff_ffff);
    for (int i = 0; i < 6; i++)
      rchk(ad[i], {4'h0, dv[i]}, {4'h0, 32'hffff_ffff});
    sc(4'h0, 4'hf, 5'h01, 5'h1f);
    bus(1'b1, 8'h0c, 2);
    bus(1'b1, 8'h10, 4);
    // Current only, trip monitor random; upstream trip clears the fault
    mag   <= 16'h0201 + 16'($random(seed) & 32'h0fff);
    ph    <= 3'($random(seed)) | 3'h4;
    mon   <= 1'($random(seed));
    fault <= 1'b1;
    wait_for(0);
    cyc(3);
    sc(4'h1, 4'hf, 5'h02, 5'h1f);
    cyc(17);
    sc(4'h3, 4'hf, 5'h04, 5'h1f);
    cyc(17);
    sc(4'h7, 4'hf, 5'h08, 5'h1f);
    cyc(15);
    sc(4'h0, 4'hf, 5'h01, 5'h1f);
    // Second coil clears the fault before the failure delay
    idle();
    heal  <= 1'b1;
    fault <= 1'b1;
    wait_for(0);
    cyc(20);
    sc(4'h3, 4'hf, 5'h04, 5'h1f);
    cyc(7);
    sc(4'h0, 4'hf, 5'h01, 5'h1f);
    heal <= 1'b0;
    idle();
    // Block raised well ahead of pick-up, then mid-start
    blk <= 1'b1;
    cyc(30);
    fault <= 1'b1;
    wait_for(3);
    cyc(3);
    sc(4'h8, 4'hf, 5'h10, 5'h1f);
    blk <= 1'b0;
    wait_for(0);
    cyc(3);
    blk <= 1'b1;
    cyc(25);
    sc(4'h8, 4'hf, 5'h10, 5'h1f);
    blk <= 1'b0;
    // Current and output: no timing without the trip monitor
    bus(1'b1, 8'h00, 32'h5);
    cyc(45);
    sc(4'h0, 4'hf, 5'h01, 5'h1f);
    mon <= 1'b1;
    wait_for(1);
    sc(4'h3, 4'h6, 5'h04, 5'h1f);
    mon <= 1'b0;
    cyc(15);
    sc(4'h0, 4'hf, 5'h01, 5'h1f);
    // Current or output: monitor alone, then handed over to current
    idle();
    bus(1'b1, 8'h00, 32'h9);
    mon <= 1'b1;
    wait_for(0);
    cyc(20);
    sc(4'h3, 4'hf, 5'h04, 5'h1f);
    fault <= 1'b1;
    mon   <= 1'b0;
    cyc(17);
    sc(4'h7, 4'hf, 5'h08, 5'h1f);
    // Retrip off; current falls inside the release band
    idle();
    bus(1'b1, 8'h00, 32'h0);
    fault <= 1'b1;
    wait_for(0);
    mag <= 16'h01f8;
    cyc(17);
    sc(4'h1, 4'hf, 5'h02, 5'h1f);
    cyc(20);
    sc(4'h5, 4'hf, 5'h08, 5'h1f);
    // Residual input alone picks up once enabled
    idle();
    bus(1'b1, 8'h00, 32'h2);
    ph    <= 3'h0;
    fault <= 1'b1;
    wait_for(0);
    rchk(8'h14, {4'h1, 32'h0000_0042}, {4'hf, 32'h0000_01ff});
    tally_and_finish();
  end
endmodule : bfs_supervisor_tb_top
